// file: hw/bc66_defs.vh
/*
 Shared constants of the 64B/66B block coder: field widths and positions,
 sync header values, block type values, XGMII control octets and their
 line codes.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef BC66_DEFS_VH
`define BC66_DEFS_VH

// Geometry of a block
`define BC66_NCH 8
`define BC66_LANES 4
`define BC66_TW 8
`define BC66_CW 7
`define BC66_OW 4
`define BC66_O0_POS 32
`define BC66_O4_POS 36
`define BC66_PAY_W 64
`define BC66_BLK_W 66

// Sync header as a vector, bit 0 sent first: 01 data, 10 control
`define BC66_SYNC_DATA 2'h2
`define BC66_SYNC_CTRL 2'h1

// Defined block type values
`define BC66_T_1E 8'h1E
`define BC66_T_2D 8'h2D
`define BC66_T_33 8'h33
`define BC66_T_66 8'h66
`define BC66_T_55 8'h55
`define BC66_T_78 8'h78
`define BC66_T_4B 8'h4B
`define BC66_T_87 8'h87
`define BC66_T_99 8'h99
`define BC66_T_AA 8'hAA
`define BC66_T_B4 8'hB4
`define BC66_T_CC 8'hCC
`define BC66_T_D2 8'hD2
`define BC66_T_E1 8'hE1
`define BC66_T_FF 8'hFF

// XGMII control octets
`define BC66_XG_IDLE 8'h07
`define BC66_XG_LPI 8'h06
`define BC66_XG_START 8'hFB
`define BC66_XG_TERM 8'hFD
`define BC66_XG_ERR 8'hFE
`define BC66_XG_SEQ 8'h9C
`define BC66_XG_SIG 8'h5C
`define BC66_XG_R0 8'h1C
`define BC66_XG_R1 8'h3C
`define BC66_XG_R2 8'h7C
`define BC66_XG_R3 8'hBC
`define BC66_XG_R4 8'hDC
`define BC66_XG_R5 8'hF7

// 7-bit line codes of the plain control characters
`define BC66_C_IDLE 7'h00
`define BC66_C_LPI 7'h06
`define BC66_C_ERR 7'h1E
`define BC66_C_R0 7'h2D
`define BC66_C_R1 7'h33
`define BC66_C_R2 7'h4B
`define BC66_C_R3 7'h55
`define BC66_C_R4 7'h66
`define BC66_C_R5 7'h78

// 4-bit ordered-set codes
`define BC66_O_SEQ 4'h0
`define BC66_O_SIG 4'hF

`endif

// file: hw/bc66_cmap.v
/*
 Maps one XGMII control octet to its 7-bit line code and back.
 Assumes the caller qualifies the result with the octet's control flag.
*/
`timescale 1ns/1ps
`include "bc66_defs.vh"

module bc66_cmap (
   input wire [7:0] xg_i,
   output reg [6:0] code_o,
   output reg enc_ok_o,
   input wire [6:0] code_i,
   output reg [7:0] xg_o,
   output reg dec_ok_o
);

   // Octet to line code; start, terminate and ordered sets have none
   always @* begin
      enc_ok_o = 1'b1;
      case (xg_i)
         `BC66_XG_IDLE: code_o = `BC66_C_IDLE;
         `BC66_XG_LPI: code_o = `BC66_C_LPI;
         `BC66_XG_ERR: code_o = `BC66_C_ERR;
         `BC66_XG_R0: code_o = `BC66_C_R0;
         `BC66_XG_R1: code_o = `BC66_C_R1;
         `BC66_XG_R2: code_o = `BC66_C_R2;
         `BC66_XG_R3: code_o = `BC66_C_R3;
         `BC66_XG_R4: code_o = `BC66_C_R4;
         `BC66_XG_R5: code_o = `BC66_C_R5;
         default: begin
            code_o = `BC66_C_ERR;
            enc_ok_o = 1'b0;
         end
      endcase
   end

   // Line code to octet; unknown codes flag an error
   always @* begin
      dec_ok_o = 1'b1;
      case (code_i)
         `BC66_C_IDLE: xg_o = `BC66_XG_IDLE;
         `BC66_C_LPI: xg_o = `BC66_XG_LPI;
         `BC66_C_ERR: xg_o = `BC66_XG_ERR;
         `BC66_C_R0: xg_o = `BC66_XG_R0;
         `BC66_C_R1: xg_o = `BC66_XG_R1;
         `BC66_C_R2: xg_o = `BC66_XG_R2;
         `BC66_C_R3: xg_o = `BC66_XG_R3;
         `BC66_C_R4: xg_o = `BC66_XG_R4;
         `BC66_C_R5: xg_o = `BC66_XG_R5;
         default: begin
            xg_o = `BC66_XG_ERR;
            dec_ok_o = 1'b0;
         end
      endcase
   end

endmodule

// file: hw/bc66_skid.v
/*
 Two-entry buffer with valid and ready on both sides.
 Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps

module bc66_skid #(
   parameter W = 66
) (
   input wire clk_i,
   input wire reset_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [W-1:0] in_data_i,
   output reg out_valid_o,
   input wire out_ready_i,
   output reg [W-1:0] out_data_o
);

   reg skid_v_r;
   reg [W-1:0] skid_d_r;

   // Full when the second entry holds a word
   assign in_ready_o = ~skid_v_r;

   // Head entry drives the output, second entry catches a stall
   always @(posedge clk_i) begin
      if (reset_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= {W{1'b0}};
         skid_v_r <= 1'b0;
         skid_d_r <= {W{1'b0}};
      end else if (in_valid_i && ~skid_v_r) begin
         if (out_valid_o && ~out_ready_i) begin
            skid_d_r <= in_data_i;
            skid_v_r <= 1'b1;
         end else begin
            out_data_o <= in_data_i;
            out_valid_o <= 1'b1;
         end
      end else if (out_ready_i) begin
         if (skid_v_r) begin
            out_data_o <= skid_d_r;
            skid_v_r <= 1'b0;
         end else begin
            out_valid_o <= 1'b0;
         end
      end
   end

endmodule

// file: hw/bc66_top.v
/*
 64B/66B block coder: packs pairs of 32-bit XGMII transfers into 66-bit
 blocks and unpacks received blocks into pairs of transfers.
 Assumes the scrambler and gearbox below, and block alignment, are
 outside; all ports are on clk_i and need no synchroniser.
*/
// What this block does
// - Every block is exactly 66 bits.
// - Sync 01 for data, 10 for control.
// - Only payload goes to scrambler; header bypasses.
// - Eight characters from two consecutive transfers.
// - Control block starts with 8-bit type field.
// - Start and terminate implied by type only.
// - Ordered sets 4-bit O code, others 7-bit.
// - Ordered set and start only at 0 or 4.
// - Data octet flag zero, control octet one.
// - Filler bits sent zero, ignored on receipt.
// - Field LSB sits in lowest block position.
// - Block bit 0 is first on the line.
// - Reserved block types never generated.
// - Undefined control codes never sent, errored received.
// - Same control set on line and XGMII.
// - Sync transition is the only alignment marker.
// - Type 0x00 and other unused types rejected.
// - Sync 00 or 11 marks block invalid.
// - Ordered set is one control, three data.
// - Encoder runs continuously from data and flags; here it takes a transfer only when tx_valid_i and tx_ready_o are high.
`timescale 1ns/1ps
`include "bc66_defs.vh"

module bc66_top (
   input wire clk_i,
   input wire reset_i,
   input wire tx_valid_i,
   output wire tx_ready_o,
   input wire [31:0] tx_d_i,
   input wire [3:0] tx_c_i,
   output wire tx_blk_valid_o,
   input wire tx_blk_ready_i,
   output wire [1:0] tx_sync_o,
   output wire [63:0] tx_payload_o,
   input wire rx_blk_valid_i,
   output wire rx_blk_ready_o,
   input wire [1:0] rx_sync_i,
   input wire [63:0] rx_payload_i,
   output wire rx_valid_o,
   input wire rx_ready_i,
   output reg [31:0] rx_d_o,
   output reg [3:0] rx_c_o,
   output reg rx_err_o,
   output reg rx_hdr_bad_o
);

   localparam NCH = `BC66_NCH;
   localparam TW = `BC66_TW;
   localparam CW = `BC66_CW;
   localparam OW = `BC66_OW;

   // ---------------- Transmit side ----------------
   reg half_r;
   reg [31:0] lo_d_r;
   reg [3:0] lo_c_r;
   wire buf_ready;
   wire [63:0] tch;
   wire [7:0] tk;
   wire [NCH*CW-1:0] tcode;
   wire [NCH-1:0] tcok;
   wire [NCH*CW-1:0] rcode;
   wire [NCH*TW-1:0] rxg;
   wire [NCH-1:0] rcok;

   // two transfers form one block, lane 0 of the first is char 0
   assign tch = {tx_d_i, lo_d_r};
   assign tk = {tx_c_i, lo_c_r};
   // Second transfer stalls while the buffer is full
   assign tx_ready_o = ~half_r | buf_ready;

   // take a transfer every cycle the source offers one while tx_ready_o is high
   always @(posedge clk_i) begin
      if (reset_i) begin
         half_r <= 1'b0;
         lo_d_r <= 32'h0;
         lo_c_r <= 4'h0;
      end else if (tx_valid_i && tx_ready_o) begin
         half_r <= ~half_r;
         if (~half_r) begin
            lo_d_r <= tx_d_i;
            lo_c_r <= tx_c_i;
         end
      end
   end

   // Per-character code mapping, both directions
   genvar g;
   generate
      for (g = 0; g < NCH; g = g + 1) begin : gmap
         bc66_cmap u_map (
            .xg_i(tch[TW*g +: TW]),
            .code_o(tcode[CW*g +: CW]),
            .enc_ok_o(tcok[g]),
            .code_i(rx_payload_i[TW + CW*g +: CW]),
            .xg_o(rxg[TW*g +: TW]),
            .dec_ok_o(rcok[g])
         );
      end
   endgenerate

   // Character classes; the flag tells data from control
   reg [7:0] isd, iss, ist, iso, isc;
   reg [7:0] t_hit;
   integer i, j, fi, pi, ri;
   always @* begin
      for (i = 0; i < NCH; i = i + 1) begin
         isd[i] = ~tk[i];
         iss[i] = tk[i] && tch[TW*i +: TW] == `BC66_XG_START;
         ist[i] = tk[i] && tch[TW*i +: TW] == `BC66_XG_TERM;
         iso[i] = tk[i] && (tch[TW*i +: TW] == `BC66_XG_SEQ ||
                            tch[TW*i +: TW] == `BC66_XG_SIG);
         // only characters with a line code count as plain control
         isc[i] = tk[i] && tcok[i];
      end
      // Terminate at n: data below, plain control above
      for (i = 0; i < NCH; i = i + 1) begin
         t_hit[i] = ist[i];
         for (j = 0; j < NCH; j = j + 1) begin
            if (j < i)
               t_hit[i] = t_hit[i] & isd[j];
            if (j > i)
               t_hit[i] = t_hit[i] & isc[j];
         end
      end
   end

   // ordered sets and starts only in lane 0 of a transfer
   // an ordered set is followed by three data characters
   wire lo_c = &isc[3:0];
   wire hi_c = &isc[7:4];
   wire lo_o = iso[0] & (&isd[3:1]);
   wire hi_o = iso[4] & (&isd[7:5]);
   wire hi_s = iss[4] & (&isd[7:5]);
   wire s_0 = iss[0] & (&isd[7:1]);

   // Format selection: type and which fields each character fills
   reg [7:0] e_type;
   reg [7:0] e_c, e_da, e_db;
   reg e_o0, e_o4, e_data, e_bad;
   always @* begin
      e_type = `BC66_T_1E;
      e_c = 8'h00;
      e_da = 8'h00;
      e_db = 8'h00;
      e_o0 = 1'b0;
      e_o4 = 1'b0;
      e_data = 1'b0;
      e_bad = 1'b0;
      if (&isd) begin
         e_data = 1'b1;
      end else if (lo_c && hi_c) begin
         e_c = 8'hFF;
      end else if (lo_c && hi_o) begin
         e_type = `BC66_T_2D;
         e_c = 8'h0F;
         e_da = 8'hE0;
         e_o4 = 1'b1;
      end else if (lo_c && hi_s) begin
         e_type = `BC66_T_33;
         e_c = 8'h0F;
         e_da = 8'hE0;
      end else if (lo_o && hi_s) begin
         e_type = `BC66_T_66;
         e_da = 8'hEE;
         e_o0 = 1'b1;
      end else if (lo_o && hi_o) begin
         e_type = `BC66_T_55;
         e_da = 8'hEE;
         e_o0 = 1'b1;
         e_o4 = 1'b1;
      end else if (s_0) begin
         e_type = `BC66_T_78;
         e_da = 8'hFE;
      end else if (lo_o && hi_c) begin
         e_type = `BC66_T_4B;
         e_da = 8'h0E;
         e_c = 8'hF0;
         e_o0 = 1'b1;
      end else if (|t_hit) begin
         // the terminate lane is told by the type alone
         case (t_hit)
            8'h01: e_type = `BC66_T_87;
            8'h02: e_type = `BC66_T_99;
            8'h04: e_type = `BC66_T_AA;
            8'h08: e_type = `BC66_T_B4;
            8'h10: e_type = `BC66_T_CC;
            8'h20: e_type = `BC66_T_D2;
            8'h40: e_type = `BC66_T_E1;
            default: e_type = `BC66_T_FF;
         endcase
         for (fi = 0; fi < NCH; fi = fi + 1) begin
            e_db[fi] = isd[fi];
            e_c[fi] = isc[fi];
         end
      end else begin
         // unmatched input becomes an error block, never a
         // reserved type
         e_bad = 1'b1;
         e_c = 8'hFF;
      end
   end

   // Payload assembly; unfilled positions stay zero
   reg [63:0] e_pay;
   reg [1:0] e_sync;
   always @* begin
      e_pay = 64'h0;
      // header value follows the block kind
      e_sync = e_data ? `BC66_SYNC_DATA : `BC66_SYNC_CTRL;
      if (e_data) begin
         e_pay = tch;
      end else begin
         // type field in payload bits 0..7, block bits 2..9
         e_pay[TW-1:0] = e_type;
         for (pi = 0; pi < NCH; pi = pi + 1) begin
            // bad input sends error codes only
            if (e_c[pi])
               e_pay[TW + CW*pi +: CW] = e_bad ? `BC66_C_ERR
                                               : tcode[CW*pi +: CW];
            if (e_da[pi])
               e_pay[TW*pi +: TW] = tch[TW*pi +: TW];
            if (e_db[pi])
               e_pay[TW + TW*pi +: TW] = tch[TW*pi +: TW];
         end
         // ordered sets carry a 4-bit code
         if (e_o0)
            e_pay[`BC66_O0_POS +: OW] =
               (tch[TW-1:0] == `BC66_XG_SIG) ? `BC66_O_SIG : `BC66_O_SEQ;
         if (e_o4)
            e_pay[`BC66_O4_POS +: OW] =
               (tch[TW*4 +: TW] == `BC66_XG_SIG) ? `BC66_O_SIG
                                                  : `BC66_O_SEQ;
      end
   end

   // block leaves as sync plus 64 payload bits, 66 in all
   // header travels beside the payload, never into the scrambler
   // payload bit k is block bit k+2, LSB first on the line
   wire [`BC66_BLK_W-1:0] buf_out;
   bc66_skid #(
      .W(`BC66_BLK_W)
   ) u_buf (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .in_valid_i(tx_valid_i & half_r),
      .in_ready_o(buf_ready),
      .in_data_i({e_pay, e_sync}),
      .out_valid_o(tx_blk_valid_o),
      .out_ready_i(tx_blk_ready_i),
      .out_data_o(buf_out)
   );
   assign tx_sync_o = buf_out[1:0];
   assign tx_payload_o = buf_out[`BC66_BLK_W-1:2];

   // ---------------- Receive side ----------------
   reg [7:0] d_c, d_da, d_db;
   reg [7:0] d_s, d_t;
   reg d_o0, d_o4, d_bad;
   wire [7:0] r_type = rx_payload_i[TW-1:0];
   // only the sync transition marks a usable block
   wire hdr_bad = ~(rx_sync_i == `BC66_SYNC_DATA ||
                    rx_sync_i == `BC66_SYNC_CTRL);

   // Type decode to field layout
   always @* begin
      d_c = 8'h00;
      d_da = 8'h00;
      d_db = 8'h00;
      d_s = 8'h00;
      d_t = 8'h00;
      d_o0 = 1'b0;
      d_o4 = 1'b0;
      d_bad = 1'b0;
      case (r_type)
         `BC66_T_1E: d_c = 8'hFF;
         `BC66_T_2D: begin
            d_c = 8'h0F;
            d_da = 8'hE0;
            d_o4 = 1'b1;
         end
         `BC66_T_33: begin
            d_c = 8'h0F;
            d_da = 8'hE0;
            d_s = 8'h10;
         end
         `BC66_T_66: begin
            d_da = 8'hEE;
            d_o0 = 1'b1;
            d_s = 8'h10;
         end
         `BC66_T_55: begin
            d_da = 8'hEE;
            d_o0 = 1'b1;
            d_o4 = 1'b1;
         end
         `BC66_T_78: begin
            d_da = 8'hFE;
            d_s = 8'h01;
         end
         `BC66_T_4B: begin
            d_da = 8'h0E;
            d_c = 8'hF0;
            d_o0 = 1'b1;
         end
         `BC66_T_87: d_t = 8'h01;
         `BC66_T_99: d_t = 8'h02;
         `BC66_T_AA: d_t = 8'h04;
         `BC66_T_B4: d_t = 8'h08;
         `BC66_T_CC: d_t = 8'h10;
         `BC66_T_D2: d_t = 8'h20;
         `BC66_T_E1: d_t = 8'h40;
         `BC66_T_FF: d_t = 8'h80;
         // 0x00 and every other unused type is rejected
         default: d_bad = 1'b1;
      endcase
      if (|d_t) begin
         d_db = d_t - 8'h01;
         d_c = ~(d_db | d_t);
      end
   end

   // Character rebuild; filler bits are never looked at
   reg [63:0] r_ch;
   reg [7:0] r_k;
   reg r_err;
   always @* begin
      r_ch = rx_payload_i;
      r_k = 8'h00;
      r_err = hdr_bad | (rx_sync_i == `BC66_SYNC_CTRL && d_bad);
      if (rx_sync_i == `BC66_SYNC_CTRL) begin
         for (ri = 0; ri < NCH; ri = ri + 1) begin
            r_k[ri] = ~(d_da[ri] | d_db[ri]);
            if (d_c[ri]) begin
               r_ch[TW*ri +: TW] = rxg[TW*ri +: TW];
               if (~rcok[ri])
                  r_err = 1'b1;
            end
            if (d_da[ri])
               r_ch[TW*ri +: TW] = rx_payload_i[TW*ri +: TW];
            if (d_db[ri])
               r_ch[TW*ri +: TW] = rx_payload_i[TW + TW*ri +: TW];
            if (d_s[ri])
               r_ch[TW*ri +: TW] = `BC66_XG_START;
            if (d_t[ri])
               r_ch[TW*ri +: TW] = `BC66_XG_TERM;
         end
         // 4-bit ordered-set codes back to octets
         if (d_o0) begin
            case (rx_payload_i[`BC66_O0_POS +: OW])
               `BC66_O_SEQ: r_ch[TW-1:0] = `BC66_XG_SEQ;
               `BC66_O_SIG: r_ch[TW-1:0] = `BC66_XG_SIG;
               default: r_err = 1'b1;
            endcase
         end
         if (d_o4) begin
            case (rx_payload_i[`BC66_O4_POS +: OW])
               `BC66_O_SEQ: r_ch[TW*4 +: TW] = `BC66_XG_SEQ;
               `BC66_O_SIG: r_ch[TW*4 +: TW] = `BC66_XG_SIG;
               default: r_err = 1'b1;
            endcase
         end
      end
      // Invalid block: every character replaced by error
      if (r_err) begin
         r_ch = {NCH{`BC66_XG_ERR}};
         r_k = 8'hFF;
      end
   end

   // Output stage: first transfer, then the held upper half
   reg out_v_r, pend_r;
   reg [31:0] hold_d_r;
   reg [3:0] hold_c_r;
   assign rx_valid_o = out_v_r;
   assign rx_blk_ready_o = ~out_v_r | (~pend_r & rx_ready_i);
   always @(posedge clk_i) begin
      if (reset_i) begin
         out_v_r <= 1'b0;
         pend_r <= 1'b0;
         hold_d_r <= 32'h0;
         hold_c_r <= 4'h0;
         rx_d_o <= 32'h0;
         rx_c_o <= 4'h0;
         rx_err_o <= 1'b0;
         rx_hdr_bad_o <= 1'b0;
      end else if (rx_blk_valid_i && rx_blk_ready_o) begin
         // control flags travel with each octet
         out_v_r <= 1'b1;
         pend_r <= 1'b1;
         rx_d_o <= r_ch[31:0];
         rx_c_o <= r_k[3:0];
         hold_d_r <= r_ch[63:32];
         hold_c_r <= r_k[7:4];
         rx_err_o <= r_err;
         rx_hdr_bad_o <= hdr_bad;
      end else if (out_v_r && rx_ready_i) begin
         if (pend_r) begin
            pend_r <= 1'b0;
            rx_d_o <= hold_d_r;
            rx_c_o <= hold_c_r;
         end else begin
            out_v_r <= 1'b0;
         end
      end
   end

endmodule

// file: verif/bc66_checker.sv
/*
 Assertions on the block coder's ports.
 Assumes the bind below and the constants header.
*/
`timescale 1ns/1ps
`include "bc66_defs.vh"

module bc66_checker (
   input wire clk_i,
   input wire reset_i,
   input wire tx_blk_valid_o,
   input wire tx_blk_ready_i,
   input wire [1:0] tx_sync_o,
   input wire [63:0] tx_payload_o,
   input wire rx_blk_valid_i,
   input wire rx_blk_ready_o,
   input wire [1:0] rx_sync_i,
   input wire [63:0] rx_payload_i,
   input wire rx_valid_o,
   input wire rx_ready_i,
   input wire [31:0] rx_d_o,
   input wire [3:0] rx_c_o,
   input wire rx_err_o,
   input wire rx_hdr_bad_o
);
   reg [31:0] lo_r;
   wire rx_in = rx_blk_valid_i && rx_blk_ready_o;
   wire tx_ctl = tx_blk_valid_o && tx_sync_o == `BC66_SYNC_CTRL;

   // Low half of each offered block, for the first transfer
   always @(posedge clk_i) begin
      lo_r <= rx_payload_i[31:0];
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   // Output block stream and decoded transfer checks
   a_sync_legal: assert property (
      tx_blk_valid_o |-> tx_sync_o inside {`BC66_SYNC_DATA, `BC66_SYNC_CTRL})
      else $error("tx sync header illegal");
   a_type_defined: assert property (
      tx_ctl |-> tx_payload_o[7:0] inside {`BC66_T_1E, `BC66_T_2D,
      `BC66_T_33, `BC66_T_66, `BC66_T_55, `BC66_T_78, `BC66_T_4B,
      `BC66_T_87, `BC66_T_99, `BC66_T_AA, `BC66_T_B4, `BC66_T_CC,
      `BC66_T_D2, `BC66_T_E1, `BC66_T_FF})
      else $error("tx block type not defined");
   a_fill_zero: assert property (
      tx_ctl && tx_payload_o[7:0] == `BC66_T_87
      |-> tx_payload_o[14:8] == 7'h00)
      else $error("tx filler bits not zero");
   a_blk_hold: assert property (
      tx_blk_valid_o && !tx_blk_ready_i |=> tx_blk_valid_o
      && $stable(tx_sync_o) && $stable(tx_payload_o))
      else $error("tx block changed while stalled");
   a_rx_hold: assert property (
      rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_d_o)
      && $stable(rx_c_o) && $stable(rx_err_o))
      else $error("rx transfer changed while stalled");
   a_hdr_bad: assert property (
      rx_in && (rx_sync_i == 2'h0 || rx_sync_i == 2'h3)
      |=> rx_valid_o && rx_hdr_bad_o && rx_err_o)
      else $error("bad sync header not flagged");
   a_err_fill: assert property (
      rx_valid_o && rx_err_o |-> rx_c_o == 4'hF && rx_d_o == 32'hFEFEFEFE)
      else $error("errored transfer not all error octets");
   a_data_lanes: assert property (
      rx_in && rx_sync_i == `BC66_SYNC_DATA
      |=> rx_valid_o && rx_c_o == 4'h0 && !rx_err_o && rx_d_o == lo_r)
      else $error("data block first transfer wrong");
   a_rsv_type: assert property (
      rx_in && rx_sync_i == `BC66_SYNC_CTRL && rx_payload_i[7:0] == 8'h00
      |=> rx_err_o && !rx_hdr_bad_o)
      else $error("reserved block type not flagged");

   c_tx_stall: cover property (tx_blk_valid_o && !tx_blk_ready_i);
   c_rx_stall: cover property (rx_valid_o && !rx_ready_i);
   c_hdr_bad: cover property (rx_valid_o && rx_hdr_bad_o);
endmodule

bind bc66_top bc66_checker u_chk (.*);

// file: verif/bc66_line_model.sv
/*
 Line side loopback model of the block stream.
 Assumes one clock; stalls and corruption on request.
*/
`timescale 1ns/1ps

module bc66_line_model (
   input wire clk_i,
   input wire reset_i,
   input wire slow_i,
   input wire stall_i,
   input wire [1:0] mangle_i,
   input wire tx_blk_valid_i,
   output reg tx_blk_ready_o,
   input wire [1:0] tx_sync_i,
   input wire [63:0] tx_payload_i,
   output reg rx_blk_valid_o,
   input wire rx_blk_ready_i,
   output reg [1:0] rx_sync_o,
   output reg [63:0] rx_payload_o
);
   reg full_nxt;

   // One block slot; released lines show the inverse of the last block
   always @(posedge clk_i) begin
      full_nxt = rx_blk_valid_o && !rx_blk_ready_i;
      if (reset_i) begin
         full_nxt = 1'b1;
         rx_blk_valid_o <= 1'b0;
         rx_sync_o <= 2'h0;
         rx_payload_o <= 64'h0;
      end else if (tx_blk_valid_i && tx_blk_ready_o) begin
         full_nxt = 1'b1;
         rx_blk_valid_o <= 1'b1;
         rx_sync_o <= (mangle_i == 2'd1) ? 2'h0 :
            (mangle_i == 2'd2) ? 2'h3 : tx_sync_i;
         rx_payload_o <= {tx_payload_i[63:8],
            (mangle_i == 2'd3) ? 8'h00 : tx_payload_i[7:0]};
      end else if (rx_blk_valid_o && rx_blk_ready_i) begin
         rx_blk_valid_o <= 1'b0;
         rx_sync_o <= ~rx_sync_o;
         rx_payload_o <= ~rx_payload_o;
      end
      tx_blk_ready_o <= !full_nxt && !stall_i && (!slow_i || $urandom % 2);
   end
endmodule

// file: verif/tb_bc66_top.sv
/*
 Self-checking loopback bench of the block coder.
 Assumes the line model and checker files.
*/
`timescale 1ns/1ps
`include "bc66_defs.vh"

module tb_bc66_top;
   localparam logic [7:0] TT [0:7] = '{`BC66_T_87, `BC66_T_99, `BC66_T_AA,
      `BC66_T_B4, `BC66_T_CC, `BC66_T_D2, `BC66_T_E1, `BC66_T_FF};
   localparam logic [7:0] XG [0:8] = '{`BC66_XG_IDLE, `BC66_XG_LPI,
      `BC66_XG_ERR, `BC66_XG_R0, `BC66_XG_R1, `BC66_XG_R2, `BC66_XG_R3,
      `BC66_XG_R4, `BC66_XG_R5};
   localparam logic [6:0] CC [0:8] = '{`BC66_C_IDLE, `BC66_C_LPI,
      `BC66_C_ERR, `BC66_C_R0, `BC66_C_R1, `BC66_C_R2, `BC66_C_R3,
      `BC66_C_R4, `BC66_C_R5};
   logic clk_i = 0, reset_i = 1, tx_valid_i = 0, rx_ready_i = 1;
   logic slow = 0, stall = 0, rx_slow = 0;
   logic [1:0] mangle = 0;
   logic [31:0] tx_d_i = 0;
   logic [3:0] tx_c_i = 0;
   logic [65:0] blk_q [$];
   logic [37:0] rx_q [$];
   integer n_fail = 0, check_count = 0;
   wire tx_ready_o, tx_blk_valid_o, tx_blk_ready_i, rx_blk_valid_i;
   wire rx_blk_ready_o, rx_valid_o, rx_err_o, rx_hdr_bad_o;
   wire [1:0] tx_sync_o, rx_sync_i;
   wire [63:0] tx_payload_o, rx_payload_i;
   wire [31:0] rx_d_o;
   wire [3:0] rx_c_o;

   bc66_top u_dut (.*);

   bc66_line_model u_line (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow),
      .stall_i(stall), .mangle_i(mangle), .tx_blk_valid_i(tx_blk_valid_o),
      .tx_blk_ready_o(tx_blk_ready_i), .tx_sync_i(tx_sync_o),
      .tx_payload_i(tx_payload_o), .rx_blk_valid_o(rx_blk_valid_i),
      .rx_blk_ready_i(rx_blk_ready_o), .rx_sync_o(rx_sync_i),
      .rx_payload_o(rx_payload_i));

   // Clock and consumer readiness
   initial forever #12.5 clk_i = ~clk_i;
   always @(posedge clk_i) #2 rx_ready_i = rx_slow ? $urandom % 2 : 1'b1;

   task check(input string name, input logic [65:0] seen,
         input logic [65:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // Expected block {error, payload, sync} for eight characters
   function automatic logic [66:0] exp_blk(input logic [63:0] d,
         input logic [7:0] c);
      logic [63:0] p;
      logic [7:0] m;
      logic bad;
      integer i, j, k;
      p = 64'h0;
      bad = 1'b0;
      k = -1;
      for (i = 0; i < 8; i++)
         if (c == (8'hFF << i) && d[8*i +: 8] == `BC66_XG_TERM) k = i;
      if (c == 8'h00) return {1'b0, d, `BC66_SYNC_DATA};
      if (c == 8'h01 && d[7:0] == `BC66_XG_START)
         return {1'b0, d[63:8], `BC66_T_78, `BC66_SYNC_CTRL};
      if (c == 8'h11 && d[7:0] == `BC66_XG_SEQ && d[39:32] == `BC66_XG_SIG)
         return {1'b0, d[63:40], `BC66_O_SIG, `BC66_O_SEQ, d[31:8],
            `BC66_T_55, `BC66_SYNC_CTRL};
      if (c != 8'hFF && k < 0) bad = 1'b1;
      for (j = 0; j < 8; j++)
         if (j < k) p[8+8*j +: 8] = d[8*j +: 8];
         else if (j > k) begin
            m = 8'h00;
            for (i = 0; i < 9; i++)
               if (d[8*j +: 8] == XG[i]) m = {1'b1, CC[i]};
            bad = bad | !m[7];
            p[8+7*j +: 7] = m[6:0];
         end
      p[7:0] = (k < 0) ? `BC66_T_1E : TT[k];
      if (bad) p = {{8{`BC66_C_ERR}}, `BC66_T_1E};
      return {bad, p, `BC66_SYNC_CTRL};
   endfunction

   task send(input logic [31:0] d, input logic [3:0] c);
      integer n;
      logic ok;
      tx_valid_i = 1'b1;
      tx_d_i = d;
      tx_c_i = c;
      n = 0;
      do begin
         @(negedge clk_i) ok = tx_ready_o;
         @(posedge clk_i) n = n + 1;
      end while (ok !== 1'b1 && n < 100);
      #2;
      if (n >= 100) check("tx ready wait", 1, 0);
   endtask

   // Notes the expected block and transfers, then offers two transfers
   task pair(input logic [63:0] d, input logic [7:0] c);
      logic [66:0] e;
      logic [71:0] x;
      e = exp_blk(d, c);
      x = (e[66] || mangle) ? {{8{`BC66_XG_ERR}}, 8'hFF} : {d, c};
      blk_q.push_back(e[65:0]);
      rx_q.push_back({^mangle, |mangle, x[3:0], x[39:8]});
      rx_q.push_back({^mangle, |mangle, x[7:4], x[71:40]});
      send(d[31:0], c[3:0]);
      send(d[63:32], c[7:4]);
   endtask

   task drain;
      integer n;
      tx_valid_i = 1'b0;
      n = 0;
      while ((blk_q.size() || rx_q.size()) && n < 500) begin
         @(posedge clk_i) #2 n = n + 1;
      end
      if (n >= 500) check("drain wait", 1, 0);
   endtask

   // Scoreboard: oldest note against each finished result
   always @(posedge clk_i) begin
      if (!reset_i && (tx_blk_valid_o & tx_blk_ready_i) === 1'b1)
         check("blk", {tx_payload_o, tx_sync_o},
            blk_q.size() ? blk_q.pop_front() : 'x);
      if (!reset_i && (rx_valid_o & rx_ready_i) === 1'b1)
         check("rx", {rx_hdr_bad_o, rx_err_o, rx_c_o, rx_d_o},
            rx_q.size() ? rx_q.pop_front() : 'x);
   end

   initial begin
      #2000000 n_fail++;
      end_of_test;
   end

   initial begin
      integer i, k;
      logic [63:0] r;
      void'($urandom(32));
      repeat (16) @(posedge clk_i);
      #2 reset_i = 1'b0;
      repeat (6) pair({$urandom, $urandom}, 8'h00);
      for (i = 0; i < 9; i++) pair({8{XG[i]}}, 8'hFF);
      r = {$urandom, $urandom};
      pair({r[63:8], `BC66_XG_START}, 8'h01);
      pair({r[63:40], `BC66_XG_SIG, r[31:8], `BC66_XG_SEQ}, 8'h11);
      pair({r[63:16], `BC66_XG_SEQ, r[7:0]}, 8'h02);
      pair({8{8'h00}}, 8'hFF);
      for (k = 0; k < 8; k++) begin
         r = {$urandom, $urandom};
         for (i = k; i < 8; i++)
            r[8*i +: 8] = (i == k) ? `BC66_XG_TERM : `BC66_XG_IDLE;
         pair(r, 8'hFF << k);
      end
      drain;
      slow = 1'b1;
      rx_slow = 1'b1;
      repeat (8) pair({$urandom, $urandom}, 8'h00);
      drain;
      slow = 1'b0;
      rx_slow = 1'b0;
      // Fill the buffer with the line stalled until input is refused
      stall = 1'b1;
      pair(r, 8'h00);
      pair(~r, 8'h00);
      fork
         pair(r ^ 64'h5A, 8'h00);
         begin
            repeat (8) @(posedge clk_i);
            #2 check("tx ready", tx_ready_o, 0);
            stall = 1'b0;
         end
      join
      drain;
      for (i = 1; i < 4; i++) begin
         mangle = i;
         pair({8{`BC66_XG_IDLE}}, 8'hFF);
         drain;
      end
      mangle = 2'd0;
      end_of_test;
   end
endmodule
